/* File: hdl/cbu_top.sv */
// conditional branch unit: decides redirect of the program counter for
// conditional branches and the skip-on-io-bit instruction, plus counters
// assumes decoder, flags and io bit come from logic on hclk
//
// Overview of operation
// RL1: io bit set skips next, two or three
// RL2: flag set branch adds offset plus one
// RL3: flag clear branch jumps when bit zero
// RL4: equal on zero one, not-equal on zero
// RL5: carry set/lower on one, clear/higher zero
// RL6: minus on negative one, plus on zero
// RL7: signed ge jumps when N xor V zero
// RL8: signed lt jumps when N xor V one
// RL9: half carry set branch on one
// RL10: half carry clear branch on zero
// RL11: transfer bit branches; no flag changed
// RL12: untaken one cycle, taken two, flush one
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cbu_params.svh"
module cbu_top
#(
	parameter int PC_W = 16
)
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic                   hready,
	input  wire logic [31:0]            hwdata,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire logic                   ins_valid,
	input  wire cbu_pkg::cbu_ins_s      ins,
	input  wire logic [PC_W-1:0]        ins_pc,
	input  wire logic [7:0]             status_register,
	input  wire logic                   io_bit,
	output logic                        ins_ready,
	output cbu_pkg::cbu_redirect_s      redirect,
	output logic [PC_W-1:0]             pc_target
);
	import cbu_pkg::*;

	if (PC_W < 8 || PC_W > 32)
	begin : g_pc_w_check
		$error("cbu_top: PC_W must lie between 8 and 32");
	end

	localparam logic [PC_W-1:0] SEQ_STEP   = PC_W'(`CBU_SEQ_STEP);
	localparam logic [PC_W-1:0] REL_STEP   = PC_W'(`CBU_REL_STEP);
	localparam logic [PC_W-1:0] SKIP1_STEP = PC_W'(`CBU_SKIP1_STEP);
	localparam logic [PC_W-1:0] SKIP2_STEP = PC_W'(`CBU_SKIP2_STEP);

	// bus side
	logic [`CBU_ADDR_W-1:0]  rd_addr;
	logic [31:0]             rd_data;
	logic                    wr_en;
	logic [`CBU_ADDR_W-1:0]  wr_addr;
	logic [31:0]             wr_data;

	// decision
	logic                    cond_true;
	logic                    accept;
	logic                    is_skip;
	logic [PC_W-1:0]         offset_ext;
	logic [PC_W-1:0]         dest;
	logic [1:0]              extra;

	// sequencer state
	cbu_state_e              state_r;
	cbu_state_e              state_nxt;
	logic [1:0]              wait_r;
	logic [1:0]              wait_nxt;
	logic                    ready_r;
	logic                    ready_nxt;
	cbu_redirect_s           redir_r;
	cbu_redirect_s           redir_nxt;
	logic [PC_W-1:0]         target_r;
	logic [PC_W-1:0]         target_nxt;
	cbu_op_e                 last_op_r;
	cbu_op_e                 last_op_nxt;
	logic                    last_taken_r;
	logic                    last_taken_nxt;

	// software state
	logic                    cnt_en_r;
	logic                    cnt_en_nxt;
	logic                    clr_req;
	logic [`CBU_CNT_W-1:0]   taken_cnt_r;
	logic [`CBU_CNT_W-1:0]   taken_cnt_nxt;
	logic [`CBU_CNT_W-1:0]   fall_cnt_r;
	logic [`CBU_CNT_W-1:0]   fall_cnt_nxt;
	logic [`CBU_CNT_W-1:0]   skip_cnt_r;
	logic [`CBU_CNT_W-1:0]   skip_cnt_nxt;

	cbu_ahb_slave u_bus
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data)
	);

	cbu_cond_eval u_cond
	(
		.op              (ins.op),
		.flag_sel        (ins.flag_sel),
		.status_register (status_register),
		.io_bit          (io_bit),
		.taken           (cond_true)
	);

	assign accept     = ins_valid & ready_r;
	assign is_skip    = (ins.op == op_skip_if_io_bit_set);
	assign offset_ext = PC_W'(signed'(ins.offset));

	// destination and number of discarded cycles
	always_comb
	begin
		if (!cond_true)
		begin
			dest  = ins_pc + SEQ_STEP; // RL12
			extra = 2'h0;              // RL12
		end
		else if (is_skip)
		begin
			// a two-word follower needs one more step and one more cycle
			dest  = ins_pc + (ins.two_word ? SKIP2_STEP : SKIP1_STEP);          // RL1
			extra = ins.two_word ? `CBU_SKIP2_EXTRA : `CBU_SKIP1_EXTRA;         // RL1
		end
		else
		begin
			dest  = ins_pc + offset_ext + REL_STEP; // RL2
			extra = `CBU_TAKEN_EXTRA;               // RL12
		end
	end

	// sequencer: ready drops for the discarded cycles
	always_comb
	begin
		state_nxt      = state_r;
		wait_nxt       = wait_r;
		ready_nxt      = ready_r;
		redir_nxt      = '0;
		target_nxt     = target_r;
		last_op_nxt    = last_op_r;
		last_taken_nxt = last_taken_r;
		unique case (state_r)
			st_idle:
			begin
				if (accept)
				begin
					redir_nxt.pc_load = 1'b1;
					redir_nxt.taken   = cond_true;
					target_nxt        = dest;
					last_op_nxt       = ins.op;
					last_taken_nxt    = cond_true;
					if (extra != 2'h0)
					begin
						state_nxt       = st_wait;
						wait_nxt        = extra;
						ready_nxt       = 1'b0;
						redir_nxt.flush = 1'b1; // RL12
					end
				end
			end
			st_wait:
			begin
				if (wait_r == 2'h1)
				begin
					state_nxt = st_idle;
					wait_nxt  = 2'h0;
					ready_nxt = 1'b1;
				end
				else
				begin
					wait_nxt        = wait_r - 2'h1;
					redir_nxt.flush = 1'b1; // RL1
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r      <= st_idle;
			wait_r       <= 2'h0;
			ready_r      <= 1'b1;
			redir_r      <= '0;
			target_r     <= '0;
			last_op_r    <= op_none;
			last_taken_r <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			wait_r       <= wait_nxt;
			ready_r      <= ready_nxt;
			redir_r      <= redir_nxt;
			target_r     <= target_nxt;
			last_op_r    <= last_op_nxt;
			last_taken_r <= last_taken_nxt;
		end
	end

	assign ins_ready = ready_r;
	assign redirect  = redir_r;
	assign pc_target = target_r;

	// control and counters; an event in the clearing cycle still counts
	assign clr_req = wr_en & (wr_addr == `CBU_CTRL_OFS) & wr_data[`CBU_CTRL_CLR];

	always_comb
	begin
		cnt_en_nxt    = cnt_en_r;
		taken_cnt_nxt = clr_req ? '0 : taken_cnt_r;
		fall_cnt_nxt  = clr_req ? '0 : fall_cnt_r;
		skip_cnt_nxt  = clr_req ? '0 : skip_cnt_r;
		if (wr_en && wr_addr == `CBU_CTRL_OFS)
		begin
			cnt_en_nxt = wr_data[`CBU_CTRL_CNT_EN];
		end
		if (accept && cnt_en_r)
		begin
			if (!cond_true)
			begin
				fall_cnt_nxt = fall_cnt_nxt + `CBU_CNT_W'(1);
			end
			else if (is_skip)
			begin
				skip_cnt_nxt = skip_cnt_nxt + `CBU_CNT_W'(1);
			end
			else
			begin
				taken_cnt_nxt = taken_cnt_nxt + `CBU_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_en_r    <= `CBU_CTRL_RST;
			taken_cnt_r <= '0;
			fall_cnt_r  <= '0;
			skip_cnt_r  <= '0;
		end
		else
		begin
			cnt_en_r    <= cnt_en_nxt;
			taken_cnt_r <= taken_cnt_nxt;
			fall_cnt_r  <= fall_cnt_nxt;
			skip_cnt_r  <= skip_cnt_nxt;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		unique case (rd_addr)
			`CBU_CTRL_OFS:
			begin
				rd_data[`CBU_CTRL_CNT_EN] = cnt_en_r;
			end
			`CBU_STAT_OFS:
			begin
				rd_data[`CBU_STAT_READY] = ready_r;
				rd_data[`CBU_STAT_TAKEN] = last_taken_r;
				rd_data[`CBU_STAT_FLUSH] = redir_r.flush;
				rd_data[`CBU_STAT_OP_LSB +: 5] = last_op_r;
			end
			`CBU_TAKEN_OFS:
			begin
				rd_data = taken_cnt_r;
			end
			`CBU_FALL_OFS:
			begin
				rd_data = fall_cnt_r;
			end
			`CBU_SKIP_OFS:
			begin
				rd_data = skip_cnt_r;
			end
			default:
			begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end
endmodule

/* File: hdl/cbu_params.svh */
// offsets, field positions, reset values and step counts of the branch unit
// definitions only; included by the reference package and the design files
`ifndef CBU_PARAMS_SVH
`define CBU_PARAMS_SVH
`define CBU_ADDR_W        8
`define CBU_CTRL_OFS      8'h00
`define CBU_STAT_OFS      8'h04
`define CBU_TAKEN_OFS     8'h08
`define CBU_FALL_OFS      8'h0C
`define CBU_SKIP_OFS      8'h10
`define CBU_CTRL_CNT_EN   0
`define CBU_CTRL_CLR      1
`define CBU_CTRL_RST      1'h1
`define CBU_STAT_READY    0
`define CBU_STAT_TAKEN    1
`define CBU_STAT_FLUSH    2
`define CBU_STAT_OP_LSB   8
`define CBU_FLAG_C        0
`define CBU_FLAG_Z        1
`define CBU_FLAG_N        2
`define CBU_FLAG_V        3
`define CBU_FLAG_H        5
`define CBU_FLAG_T        6
`define CBU_SEQ_STEP      1
`define CBU_REL_STEP      1
`define CBU_SKIP1_STEP    2
`define CBU_SKIP2_STEP    3
`define CBU_TAKEN_EXTRA   2'h1
`define CBU_SKIP1_EXTRA   2'h1
`define CBU_SKIP2_EXTRA   2'h2
`define CBU_CNT_W         32
`endif

/* File: hdl/cbu_pkg.sv */
// types shared by the branch unit: decoded operations, carriers
// assumes the decoder delivers one decoded conditional instruction at a time
package cbu_pkg;
	typedef enum logic [4:0] {
		op_none                        = 5'h00,
		op_skip_if_io_bit_set          = 5'h01,
		op_branch_on_flag_set          = 5'h02,
		op_branch_on_flag_clear        = 5'h03,
		op_branch_if_equal             = 5'h04,
		op_branch_if_not_equal         = 5'h05,
		op_branch_if_carry_set         = 5'h06,
		op_branch_if_carry_clear       = 5'h07,
		op_branch_if_same_or_higher    = 5'h08,
		op_branch_if_lower             = 5'h09,
		op_branch_if_minus             = 5'h0A,
		op_branch_if_plus              = 5'h0B,
		op_branch_if_signed_ge         = 5'h0C,
		op_branch_if_signed_lt         = 5'h0D,
		op_branch_if_halfcarry_set     = 5'h0E,
		op_branch_if_halfcarry_clear   = 5'h0F,
		op_branch_if_transfer_bit_set  = 5'h10,
		op_branch_if_transfer_bit_clear = 5'h11
	} cbu_op_e;

	typedef struct packed {
		cbu_op_e    op;
		logic [2:0] flag_sel;
		logic [6:0] offset;
		logic       two_word;
	} cbu_ins_s;

	typedef struct packed {
		logic pc_load;
		logic flush;
		logic taken;
	} cbu_redirect_s;

	typedef enum logic {
		st_idle = 1'b0,
		st_wait = 1'b1
	} cbu_state_e;
endpackage

/* File: hdl/cbu_cond_eval.sv */
// condition test of one decoded branch or skip against the status flags
// assumes status_register and io_bit are stable for the cycle of the test
`timescale 1ns/1ps
`include "cbu_params.svh"
module cbu_cond_eval
(
	input  wire cbu_pkg::cbu_op_e op,
	input  wire logic [2:0]       flag_sel,
	input  wire logic [7:0]       status_register,
	input  wire logic             io_bit,
	output logic                  taken
);
	import cbu_pkg::*;

	logic flag_c;
	logic flag_z;
	logic flag_n;
	logic flag_v;

	assign flag_c = status_register[`CBU_FLAG_C];
	assign flag_z = status_register[`CBU_FLAG_Z];
	assign flag_n = status_register[`CBU_FLAG_N];
	assign flag_v = status_register[`CBU_FLAG_V];

	// the flags are only read, never written back
	always_comb
	begin
		unique case (op)
			op_skip_if_io_bit_set:           taken = io_bit;                        // RL1
			op_branch_on_flag_set:           taken = status_register[flag_sel];     // RL2
			op_branch_on_flag_clear:         taken = ~status_register[flag_sel];    // RL3
			op_branch_if_equal:              taken = flag_z;                        // RL4
			op_branch_if_not_equal:          taken = ~flag_z;                       // RL4
			op_branch_if_carry_set:          taken = flag_c;                        // RL5
			op_branch_if_lower:              taken = flag_c;                        // RL5
			op_branch_if_carry_clear:        taken = ~flag_c;                       // RL5
			op_branch_if_same_or_higher:     taken = ~flag_c;                       // RL5
			op_branch_if_minus:              taken = flag_n;                        // RL6
			op_branch_if_plus:               taken = ~flag_n;                       // RL6
			op_branch_if_signed_ge:          taken = ~(flag_n ^ flag_v);            // RL7
			op_branch_if_signed_lt:          taken = flag_n ^ flag_v;               // RL8
			op_branch_if_halfcarry_set:      taken = status_register[`CBU_FLAG_H];  // RL9
			op_branch_if_halfcarry_clear:    taken = ~status_register[`CBU_FLAG_H]; // RL10
			op_branch_if_transfer_bit_set:   taken = status_register[`CBU_FLAG_T];  // RL11
			op_branch_if_transfer_bit_clear: taken = ~status_register[`CBU_FLAG_T]; // RL11
			default:                         taken = 1'b0;
		endcase
	end
endmodule

/* File: hdl/cbu_ahb_slave.sv */
// zero-wait AHB-Lite slave front end of the branch unit registers
// assumes the register file answers reads combinationally from rd_addr
`timescale 1ns/1ps
`include "cbu_params.svh"
module cbu_ahb_slave
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic                   hready,
	input  wire logic [31:0]            hwdata,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	output logic [`CBU_ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]            rd_data,
	output logic                        wr_en,
	output logic [`CBU_ADDR_W-1:0]      wr_addr,
	output logic [31:0]                 wr_data
);
	logic                   acc;
	logic                   wr_pend_r;
	logic                   wr_pend_nxt;
	logic [`CBU_ADDR_W-1:0] wr_addr_r;
	logic [`CBU_ADDR_W-1:0] wr_addr_nxt;
	logic [31:0]            hrdata_r;
	logic [31:0]            hrdata_nxt;

	// only whole-word transfers are served; narrower ones read zero
	assign acc     = hsel & htrans[1] & hready & (hsize == 3'h2);
	assign rd_addr = haddr[`CBU_ADDR_W-1:0];

	always_comb
	begin
		wr_pend_nxt = acc & hwrite;
		wr_addr_nxt = acc ? haddr[`CBU_ADDR_W-1:0] : wr_addr_r;
		hrdata_nxt  = (acc & ~hwrite) ? rd_data : 32'h0000_0000;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			hrdata_r  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r  <= hrdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
	assign wr_en     = wr_pend_r;
	assign wr_addr   = wr_addr_r;
	assign wr_data   = hwdata;
endmodule

/* File: verif/cbu_ref_pkg.sv */
// reference decision of one conditional branch or skip, for checker and bench
// assumes the op codes and flag positions of the design package
`include "cbu_params.svh"
package cbu_ref_pkg;
	import cbu_pkg::*;
	function automatic logic cbu_ref_cond(cbu_op_e op, logic [2:0] fs, logic [7:0] s,
		logic io);
		case (op)
			op_skip_if_io_bit_set: return io;
			op_branch_on_flag_set: return s[fs];
			op_branch_on_flag_clear: return !s[fs];
			op_branch_if_equal: return s[`CBU_FLAG_Z];
			op_branch_if_not_equal: return !s[`CBU_FLAG_Z];
			op_branch_if_carry_set, op_branch_if_lower: return s[`CBU_FLAG_C];
			op_branch_if_carry_clear, op_branch_if_same_or_higher: return !s[`CBU_FLAG_C];
			op_branch_if_minus: return s[`CBU_FLAG_N];
			op_branch_if_plus: return !s[`CBU_FLAG_N];
			op_branch_if_signed_ge: return !(s[`CBU_FLAG_N] ^ s[`CBU_FLAG_V]);
			op_branch_if_signed_lt: return s[`CBU_FLAG_N] ^ s[`CBU_FLAG_V];
			op_branch_if_halfcarry_set: return s[`CBU_FLAG_H];
			op_branch_if_halfcarry_clear: return !s[`CBU_FLAG_H];
			op_branch_if_transfer_bit_set: return s[`CBU_FLAG_T];
			op_branch_if_transfer_bit_clear: return !s[`CBU_FLAG_T];
			default: return 1'b0;
		endcase
	endfunction
endpackage

/* File: verif/cbu_fetch_model.sv */
// model of the core program counter that follows the unit's redirects
// assumes redirect and pc_target are registered on hclk
`timescale 1ns/1ps
module cbu_fetch_model
#(
	parameter int              PC_W  = 16,
	parameter logic [PC_W-1:0] START = 16'h0040
)
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire cbu_pkg::cbu_redirect_s redirect,
	input  wire logic [PC_W-1:0]        pc_target,
	output logic [PC_W-1:0]             pc,
	output logic [31:0]                 discards
);
	import cbu_pkg::*;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [31:0]     disc_r, disc_nxt;
	// fetch address mux: a redirect wins in the very cycle it appears
	always_comb
	begin
		pc_nxt = redirect.pc_load ? pc_target : pc_r;
		disc_nxt = disc_r + 32'(redirect.flush);
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pc_r <= START;
			disc_r <= '0;
		end
		else
		begin
			pc_r <= pc_nxt;
			disc_r <= disc_nxt;
		end
	end
	assign pc = pc_nxt;
	assign discards = disc_r;
endmodule

/* File: verif/cbu_top_monitor.sv */
// checker of the branch decision and redirect timing of the unit
// assumes it is bound into cbu_top and sees only its ports
`timescale 1ns/1ps
module cbu_top_monitor
#(
	parameter int PC_W = 16
)
(
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   ins_valid,
	input wire cbu_pkg::cbu_ins_s      ins,
	input wire logic [PC_W-1:0]        ins_pc,
	input wire logic [7:0]             status_register,
	input wire logic                   io_bit,
	input wire logic                   ins_ready,
	input wire cbu_pkg::cbu_redirect_s redirect,
	input wire logic [PC_W-1:0]        pc_target
);
	import cbu_pkg::*;
	import cbu_ref_pkg::*;
	logic            take, cond, cond_q;
	cbu_ins_s        ins_q;
	logic [PC_W-1:0] pc_q;
	assign take = ins_valid && ins_ready;
	assign cond = cbu_ref_cond(ins.op, ins.flag_sel, status_register, io_bit);
	// offer captured so the answer can be judged one cycle later
	always_ff @(posedge hclk)
	begin
		ins_q <= ins;
		pc_q <= ins_pc;
		cond_q <= cond;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_discard;
		redirect.flush && !ins_ready;
	endsequence
	sequence s_resume;
		!redirect.flush && ins_ready && !redirect.pc_load;
	endsequence
	property p_answer;
		take |=> redirect.pc_load;
	endproperty
	a_answer: assert property (p_answer) else $error("no redirect after take");
	property p_decide;
		take |=> redirect.taken == cond_q;
	endproperty
	a_decide: assert property (p_decide) else $error("wrong decision");
	property p_fall;
		take && !cond |=> pc_target == pc_q + PC_W'(1) && ins_ready && !redirect.flush;
	endproperty
	a_fall: assert property (p_fall) else $error("bad fall through");
	property p_rel;
		take && cond && ins.op != op_skip_if_io_bit_set |=>
			pc_target == pc_q + PC_W'(signed'(ins_q.offset)) + PC_W'(1) ##0 s_discard ##1 s_resume;
	endproperty
	a_rel: assert property (p_rel) else $error("bad relative jump");
	property p_skip1;
		take && cond && ins.op == op_skip_if_io_bit_set && !ins.two_word |=>
			pc_target == pc_q + PC_W'(2) ##0 s_discard ##1 s_resume;
	endproperty
	a_skip1: assert property (p_skip1) else $error("bad short skip");
	property p_skip2;
		take && cond && ins.op == op_skip_if_io_bit_set && ins.two_word |=>
			pc_target == pc_q + PC_W'(3) ##0 s_discard [*2] ##1 s_resume;
	endproperty
	a_skip2: assert property (p_skip2) else $error("bad long skip");
	property p_refuse;
		ins_valid && !ins_ready |=> !redirect.pc_load;
	endproperty
	a_refuse: assert property (p_refuse) else $error("offer taken while busy");
	property p_pulse;
		redirect.taken |-> redirect.pc_load ##1 !redirect.taken;
	endproperty
	a_pulse: assert property (p_pulse) else $error("taken pulse malformed");
	property p_hold;
		!redirect.pc_load |-> $stable(pc_target);
	endproperty
	a_hold: assert property (p_hold) else $error("target moved");
endmodule
bind cbu_top cbu_top_monitor #(.PC_W(PC_W)) mon
(
	.hclk(hclk), .hresetn(hresetn), .ins_valid(ins_valid), .ins(ins), .ins_pc(ins_pc),
	.status_register(status_register), .io_bit(io_bit), .ins_ready(ins_ready),
	.redirect(redirect), .pc_target(pc_target)
);

/* File: verif/cbu_top_test.sv */
// self-checking bench of the branch unit: every op against flag patterns, registers
// assumes the fetch model supplies the pc and the checker is bound in
`timescale 1ns/1ps
`include "cbu_params.svh"
module cbu_top_test;
	import cbu_pkg::*;
	import cbu_ref_pkg::*;
	localparam int PW = 16;
	logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic          ins_valid = 1'b0, io_bit = 1'b0, hready, hresp, ins_ready;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   haddr = '0, hwdata = '0, hrdata, discards, v;
	logic [7:0]    status_register = 8'h00;
	logic [PW-1:0] ins_pc = '0, pc_target, pc_m;
	cbu_ins_s      ins = '0;
	cbu_redirect_s redirect;
	int            bad_count = 0, n_compared = 0, exp_disc = 0;
	logic [7:0]    srtab [8] = '{8'h00, 8'hFF, 8'h02, 8'h01, 8'h04, 8'h0C, 8'h20, 8'h40};
	cbu_top #(.PC_W(PW)) uut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ins_valid(ins_valid),
		.ins(ins), .ins_pc(ins_pc), .status_register(status_register), .io_bit(io_bit),
		.ins_ready(ins_ready), .redirect(redirect), .pc_target(pc_target)
	);
	cbu_fetch_model #(.PC_W(PW)) fetch
	(
		.hclk(hclk), .hresetn(hresetn), .redirect(redirect), .pc_target(pc_target),
		.pc(pc_m), .discards(discards)
	);
	always #10 hclk = ~hclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rdv = hrdata;
		chk(32'(hresp), 32'h0000_0000);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, '0, r);
		chk(r, exp);
	endtask
	// one offer; a taken one keeps valid up into the discard cycle to be refused
	task automatic run(input cbu_op_e op, input logic [2:0] fs, input logic [6:0] k,
		input logic tw, input logic [7:0] sr, input logic io);
		logic          tk;
		logic [PW-1:0] e;
		int            x;
		tk = cbu_ref_cond(op, fs, sr, io);
		x = !tk ? 0 : (op == op_skip_if_io_bit_set && tw) ? 2 : 1;
		if (!tk)
			e = pc_m + PW'(1);
		else if (op == op_skip_if_io_bit_set)
			e = pc_m + (tw ? PW'(3) : PW'(2));
		else
			e = pc_m + PW'(signed'(k)) + PW'(1);
		ins_valid <= 1'b1;
		ins <= '{op, fs, k, tw};
		ins_pc <= pc_m;
		status_register <= sr;
		io_bit <= io;
		@(posedge hclk);
		ins_valid <= (x > 0);
		#1;
		chk(32'({redirect.pc_load, redirect.taken}), 32'({1'b1, tk}));
		chk(32'(pc_target), 32'(e));
		chk(32'({redirect.flush, ins_ready}), 32'({x > 0, x == 0}));
		for (int i = 1; i <= x; i++)
		begin
			@(posedge hclk);
			ins_valid <= 1'b0;
			#1;
			chk(32'({redirect.pc_load, redirect.flush, ins_ready}), 32'({1'b0, i < x, i == x}));
		end
		exp_disc += x;
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd_chk(32'(4 * i), (i < 2) ? 32'h0000_0001 : 32'h0000_0000);
		$display("register reset values done");
		for (int o = 0; o < 18; o++)
			for (int j = 0; j < 8; j++)
				run(cbu_op_e'(o), 3'(j), j[0] ? 7'h3F : 7'h40, j[1], srtab[j], j[2]);
		chk(discards, 32'(exp_disc));
		$display("decisions done");
		bus(1'b1, 32'(`CBU_CTRL_OFS), 32'h0000_0003, v);
		run(op_branch_if_equal, 3'h0, 7'h01, 1'b0, 8'h02, 1'b0);
		run(op_skip_if_io_bit_set, 3'h0, 7'h00, 1'b1, 8'h00, 1'b1);
		run(op_branch_if_equal, 3'h0, 7'h01, 1'b0, 8'h00, 1'b0);
		rd_chk(32'(`CBU_CTRL_OFS), 32'h0000_0001);
		rd_chk(32'(`CBU_TAKEN_OFS), 32'h0000_0001);
		rd_chk(32'(`CBU_FALL_OFS), 32'h0000_0001);
		rd_chk(32'(`CBU_SKIP_OFS), 32'h0000_0001);
		rd_chk(32'(`CBU_STAT_OFS), 32'h0000_0401);
		bus(1'b1, 32'(`CBU_CTRL_OFS), 32'h0000_0000, v);
		run(op_branch_if_equal, 3'h0, 7'h01, 1'b0, 8'h02, 1'b0);
		rd_chk(32'(`CBU_TAKEN_OFS), 32'h0000_0001);
		rd_chk(32'(`CBU_STAT_OFS), 32'h0000_0403);
		bus(1'b1, 32'h0000_0014, 32'hFFFF_FFFF, v);
		rd_chk(32'h0000_0014, 32'h0000_0000);
		$display("registers done");
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		#1;
		chk(32'({redirect, ins_ready, pc_target}), 32'h0001_0000);
		@(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(32'(`CBU_CTRL_OFS), 32'h0000_0001);
		run(op_branch_if_minus, 3'h0, 7'h7F, 1'b0, 8'h04, 1'b0);
		$display("reset recovery done");
		final_report;
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		final_report;
	end
endmodule
